/* tpg_gpio.v */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "tpg_defines.vh"

// What this block does
// - Direction bit: 0 input, 1 push-pull
// - Pull-up bit: 0 floating, 1 pull-up
// - Output pins read back actual pin state
// - Pull-up input rests high, low externally
// - Bits 7:6 set port 2 upper drive
// - Bits 5:4 set port 2 lower drive
// - Bits 3:2 set port 0 upper drive
// - Bits 1:0 set port 0 lower drive
// - Eighteen pins; other positions unimplemented
// - Port 0 pins 0-4 half-supply display output
module tpg_gpio #(
   parameter ADDR_WIDTH = 12
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // AXI4-Lite write address
   input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Port pads
   input wire [7:0] port0PadIn,
   input wire [7:0] port1PadIn,
   input wire [7:0] port2PadIn,
   output wire [7:0] port0PadOut,
   output wire [7:0] port1PadOut,
   output wire [7:0] port2PadOut,
   output wire [7:0] port0PadOe,
   output wire [7:0] port1PadOe,
   output wire [7:0] port2PadOe,
   output wire [7:0] port0Pullup,
   output wire [7:0] port1Pullup,
   output wire [7:0] port2Pullup,
   output wire [7:0] port0HalfSupply,
   // Source drive levels per nibble
   output reg [1:0] port2UpperDriveLevel,
   output reg [1:0] port2LowerDriveLevel,
   output reg [1:0] port0UpperDriveLevel,
   output reg [1:0] port0LowerDriveLevel
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] port0Data_ff;
   reg [7:0] port1Data_ff;
   reg [7:0] port2Data_ff;
   reg [7:0] port0Dir_ff;
   reg [7:0] port1Dir_ff;
   reg [7:0] port2Dir_ff;
   reg [7:0] port0Pull_ff;
   reg [7:0] port1Pull_ff;
   reg [7:0] port2Pull_ff;
   reg [7:0] driveCfg_ff;
   reg [7:0] dispCom_ff;

   // Next register values
   reg [7:0] nxt_port0Data;
   reg [7:0] nxt_port1Data;
   reg [7:0] nxt_port2Data;
   reg [7:0] nxt_port0Dir;
   reg [7:0] nxt_port1Dir;
   reg [7:0] nxt_port2Dir;
   reg [7:0] nxt_port0Pull;
   reg [7:0] nxt_port1Pull;
   reg [7:0] nxt_port2Pull;
   reg [7:0] nxt_driveCfg;
   reg [7:0] nxt_dispCom;

   // Write channel holding state
   reg awHeld_ff;
   reg wHeld_ff;
   reg [ADDR_WIDTH-1:0] awAddr_ff;
   reg [7:0] wByte_ff;
   reg wLane0_ff;

   wire [7:0] port0Read;
   wire [7:0] port1Read;
   wire [7:0] port2Read;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function [3:0] regSel;
      input [ADDR_WIDTH-1:0] addr;
      reg [ADDR_WIDTH-1:0] idx;
      begin
         regSel = 4'hf;
         idx = addr >> 2;
         // Only aligned words within the index range decode
         if (addr[1:0] == 2'h0 && idx[ADDR_WIDTH-1:8] == 0) begin
            case (idx[7:0])
               `TPG_IDX_PORT0_DATA: regSel = 4'h0;
               `TPG_IDX_PORT1_DATA: regSel = 4'h1;
               `TPG_IDX_PORT1_DIR: regSel = 4'h2;
               `TPG_IDX_PORT1_PULL: regSel = 4'h3;
               `TPG_IDX_DRIVE_CFG: regSel = 4'h4;
               `TPG_IDX_PORT0_DIR: regSel = 4'h5;
               `TPG_IDX_PORT0_PULL: regSel = 4'h6;
               `TPG_IDX_DISP_COM: regSel = 4'h7;
               `TPG_IDX_PORT2_DATA: regSel = 4'h8;
               `TPG_IDX_PORT2_DIR: regSel = 4'h9;
               `TPG_IDX_PORT2_PULL: regSel = 4'ha;
               default: regSel = 4'hf;
            endcase
         end
      end
   endfunction

   wire [3:0] wrSel = regSel(awAddr_ff);
   wire [3:0] rdSel = regSel(s_axi_araddr);
   wire doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
   wire wrLive = doWrite && wLane0_ff;

   // ----------------------------------------
   // Write path
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TPG_RESP_OKAY;
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= {ADDR_WIDTH{1'b0}};
         wByte_ff <= `TPG_RESET_BYTE;
         wLane0_ff <= 1'b0;
      end else begin
         // Ready pulses for one cycle while a slot is free
         s_axi_awready <= !awHeld_ff && s_axi_awvalid && !s_axi_awready;
         s_axi_wready <= !wHeld_ff && s_axi_wvalid && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wByte_ff <= s_axi_wdata[7:0];
            wLane0_ff <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrSel == 4'hf) ? `TPG_RESP_SLVERR : `TPG_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Byte lane 0 off or an unmapped address leaves every register alone
   always @* begin
      nxt_port0Data = port0Data_ff;
      nxt_port1Data = port1Data_ff;
      nxt_port2Data = port2Data_ff;
      nxt_port0Dir = port0Dir_ff;
      nxt_port1Dir = port1Dir_ff;
      nxt_port2Dir = port2Dir_ff;
      nxt_port0Pull = port0Pull_ff;
      nxt_port1Pull = port1Pull_ff;
      nxt_port2Pull = port2Pull_ff;
      nxt_driveCfg = driveCfg_ff;
      nxt_dispCom = dispCom_ff;
      if (wrLive) begin
         case (wrSel)
            4'h0: nxt_port0Data = wByte_ff & `TPG_MASK_PORT0;
            4'h1: nxt_port1Data = wByte_ff & `TPG_MASK_PORT1;
            4'h2: nxt_port1Dir = wByte_ff & `TPG_MASK_PORT1;
            4'h3: nxt_port1Pull = wByte_ff & `TPG_MASK_PORT1;
            4'h4: nxt_driveCfg = wByte_ff;
            4'h5: nxt_port0Dir = wByte_ff & `TPG_MASK_PORT0;
            4'h6: nxt_port0Pull = wByte_ff & `TPG_MASK_PORT0;
            4'h7: nxt_dispCom = wByte_ff & `TPG_MASK_DISP;
            4'h8: nxt_port2Data = wByte_ff & `TPG_MASK_PORT2;
            4'h9: nxt_port2Dir = wByte_ff & `TPG_MASK_PORT2;
            4'ha: nxt_port2Pull = wByte_ff & `TPG_MASK_PORT2;
            default: nxt_dispCom = dispCom_ff;
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         port0Data_ff <= `TPG_RESET_BYTE;
         port1Data_ff <= `TPG_RESET_BYTE;
         port2Data_ff <= `TPG_RESET_BYTE;
         port0Dir_ff <= `TPG_RESET_BYTE;
         port1Dir_ff <= `TPG_RESET_BYTE;
         port2Dir_ff <= `TPG_RESET_BYTE;
         port0Pull_ff <= `TPG_RESET_BYTE;
         port1Pull_ff <= `TPG_RESET_BYTE;
         port2Pull_ff <= `TPG_RESET_BYTE;
         driveCfg_ff <= `TPG_RESET_BYTE;
         dispCom_ff <= `TPG_RESET_BYTE;
      end else begin
         port0Data_ff <= nxt_port0Data;
         port1Data_ff <= nxt_port1Data;
         port2Data_ff <= nxt_port2Data;
         port0Dir_ff <= nxt_port0Dir;
         port1Dir_ff <= nxt_port1Dir;
         port2Dir_ff <= nxt_port2Dir;
         port0Pull_ff <= nxt_port0Pull;
         port1Pull_ff <= nxt_port1Pull;
         port2Pull_ff <= nxt_port2Pull;
         driveCfg_ff <= nxt_driveCfg;
         dispCom_ff <= nxt_dispCom;
      end
   end

   // ----------------------------------------
   // Drive levels
   // ----------------------------------------
   // Registered out; 00 strongest, 11 weakest
   always @(posedge sys_clk) begin
      if (reset) begin
         port2UpperDriveLevel <= 2'h0;
         port2LowerDriveLevel <= 2'h0;
         port0UpperDriveLevel <= 2'h0;
         port0LowerDriveLevel <= 2'h0;
      end else begin
         port2UpperDriveLevel <= driveCfg_ff[`TPG_PORT2_UPPER_MSB:`TPG_PORT2_UPPER_LSB];
         port2LowerDriveLevel <= driveCfg_ff[`TPG_PORT2_LOWER_MSB:`TPG_PORT2_LOWER_LSB];
         port0UpperDriveLevel <= driveCfg_ff[`TPG_PORT0_UPPER_MSB:`TPG_PORT0_UPPER_LSB];
         port0LowerDriveLevel <= driveCfg_ff[`TPG_PORT0_LOWER_MSB:`TPG_PORT0_LOWER_LSB];
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   reg [7:0] rdByte;
   always @* begin
      rdByte = `TPG_RESET_BYTE;
      case (rdSel)
         4'h0: rdByte = port0Read;
         4'h1: rdByte = port1Read;
         4'h2: rdByte = port1Dir_ff;
         4'h3: rdByte = port1Pull_ff;
         4'h4: rdByte = driveCfg_ff;
         4'h5: rdByte = port0Dir_ff;
         4'h6: rdByte = port0Pull_ff;
         4'h7: rdByte = dispCom_ff;
         4'h8: rdByte = port2Read;
         4'h9: rdByte = port2Dir_ff;
         4'ha: rdByte = port2Pull_ff;
         default: rdByte = `TPG_RESET_BYTE;
      endcase
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TPG_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rdByte};
            s_axi_rresp <= (rdSel == 4'hf) ? `TPG_RESP_SLVERR : `TPG_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Port instances
   // ----------------------------------------
   // Unimplemented pins are masked by IMPL_MASK and never driven
   tpg_port #(.IMPL_MASK(`TPG_MASK_PORT0)) port0Inst (
      .sys_clk(sys_clk),
      .reset(reset),
      .dirBits(port0Dir_ff),
      .pullBits(port0Pull_ff),
      .dataLatch(port0Data_ff),
      .dispBits(dispCom_ff),
      .padIn(port0PadIn),
      .padOut(port0PadOut),
      .padOe(port0PadOe),
      .padPullup(port0Pullup),
      .padHalfSupply(port0HalfSupply),
      .readValue(port0Read)
   );

   tpg_port #(.IMPL_MASK(`TPG_MASK_PORT1)) port1Inst (
      .sys_clk(sys_clk),
      .reset(reset),
      .dirBits(port1Dir_ff),
      .pullBits(port1Pull_ff),
      .dataLatch(port1Data_ff),
      .dispBits(8'h00),
      .padIn(port1PadIn),
      .padOut(port1PadOut),
      .padOe(port1PadOe),
      .padPullup(port1Pullup),
      .padHalfSupply(),
      .readValue(port1Read)
   );

   tpg_port #(.IMPL_MASK(`TPG_MASK_PORT2)) port2Inst (
      .sys_clk(sys_clk),
      .reset(reset),
      .dirBits(port2Dir_ff),
      .pullBits(port2Pull_ff),
      .dataLatch(port2Data_ff),
      .dispBits(8'h00),
      .padIn(port2PadIn),
      .padOut(port2PadOut),
      .padOe(port2PadOe),
      .padPullup(port2Pullup),
      .padHalfSupply(),
      .readValue(port2Read)
   );

endmodule // tpg_gpio

/* tpg_defines.vh */
`ifndef TPG_DEFINES_VH
`define TPG_DEFINES_VH

// ----------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------
`define TPG_IDX_PORT0_DATA 8'h80
`define TPG_IDX_PORT1_DATA 8'h90
`define TPG_IDX_PORT1_DIR 8'h91
`define TPG_IDX_PORT1_PULL 8'h92
`define TPG_IDX_DRIVE_CFG 8'h97
`define TPG_IDX_PORT0_DIR 8'h9a
`define TPG_IDX_PORT0_PULL 8'h9b
`define TPG_IDX_DISP_COM 8'h9c
`define TPG_IDX_PORT2_DATA 8'ha0
`define TPG_IDX_PORT2_DIR 8'ha1
`define TPG_IDX_PORT2_PULL 8'ha2

// ----------------------------------------
// Implemented bit masks per port
// ----------------------------------------
`define TPG_MASK_PORT0 8'h3f
`define TPG_MASK_PORT1 8'hcf
`define TPG_MASK_PORT2 8'hf3
`define TPG_MASK_DISP 8'h1f

// ----------------------------------------
// Drive level fields
// ----------------------------------------
`define TPG_PORT2_UPPER_MSB 7
`define TPG_PORT2_UPPER_LSB 6
`define TPG_PORT2_LOWER_MSB 5
`define TPG_PORT2_LOWER_LSB 4
`define TPG_PORT0_UPPER_MSB 3
`define TPG_PORT0_UPPER_LSB 2
`define TPG_PORT0_LOWER_MSB 1
`define TPG_PORT0_LOWER_LSB 0

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define TPG_RESET_BYTE 8'h00
`define TPG_RESP_OKAY 2'h0
`define TPG_RESP_SLVERR 2'h2

`endif

/* tpg_port.v */
`timescale 1ns/1ps
`include "tpg_defines.vh"

// One 8-bit port: pad control and synchronised read-back
module tpg_port #(
   parameter [7:0] IMPL_MASK = 8'hff
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Configuration
   input wire [7:0] dirBits,
   input wire [7:0] pullBits,
   input wire [7:0] dataLatch,
   input wire [7:0] dispBits,
   // Pads
   input wire [7:0] padIn,
   output reg [7:0] padOut,
   output reg [7:0] padOe,
   output reg [7:0] padPullup,
   output reg [7:0] padHalfSupply,
   // Read-back
   output wire [7:0] readValue
);

   reg [7:0] sync1_ff;
   reg [7:0] sync2_ff;

   always @(posedge sys_clk) begin
      if (reset) begin
         sync1_ff <= `TPG_RESET_BYTE;
         sync2_ff <= `TPG_RESET_BYTE;
         padOut <= `TPG_RESET_BYTE;
         padOe <= `TPG_RESET_BYTE;
         padPullup <= `TPG_RESET_BYTE;
         padHalfSupply <= `TPG_RESET_BYTE;
      end else begin
         sync1_ff <= padIn;
         sync2_ff <= sync1_ff;
         padOut <= dataLatch & IMPL_MASK;
         // Half-supply override takes the pad off push-pull
         padOe <= dirBits & ~dispBits & IMPL_MASK;
         padHalfSupply <= dispBits & IMPL_MASK;
         // Pull-up only meaningful while an input
         padPullup <= pullBits & ~dirBits & IMPL_MASK;
      end
   end

   // Output pins read their actual pad level too
   assign readValue = sync2_ff & IMPL_MASK;

endmodule // tpg_port

/* tpg_gpio_properties.sv */
`timescale 1ns/1ps
module tpg_gpio_properties #(
   parameter ADDR_WIDTH = 12
) (
   // Bus
   input wire sys_clk,
   input wire reset,
   input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Pads
   input wire [7:0] port0PadOe,
   input wire [7:0] port1PadOe,
   input wire [7:0] port2PadOe,
   input wire [7:0] port0Pullup,
   input wire [7:0] port0HalfSupply,
   input wire [1:0] port2UpperDriveLevel,
   input wire [1:0] port2LowerDriveLevel,
   input wire [1:0] port0UpperDriveLevel,
   input wire [1:0] port0LowerDriveLevel
);
   reg [7:0] wByte_ff;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (reset);
   always @(posedge sys_clk) begin
      if (s_axi_wvalid && s_axi_wready) wByte_ff <= s_axi_wdata[7:0];
   end
   sequence cfgTaken;
      s_axi_awvalid && s_axi_awready && s_axi_awaddr == 12'h25c && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
   endsequence
   sequence levelsFollow;
      ##[0:2] {port2UpperDriveLevel, port2LowerDriveLevel, port0UpperDriveLevel, port0LowerDriveLevel} == wByte_ff;
   endsequence
   chk_level_update: assert property (cfgTaken |=> levelsFollow)
      else $error("drive levels off");
   chk_unimpl_quiet: assert property ({port0PadOe[7:6], port1PadOe[5:4], port2PadOe[3:2]} == 6'h00)
      else $error("unimplemented pin driven");
   chk_pull_gated: assert property ((port0Pullup & port0PadOe) == 8'h00)
      else $error("pull-up on driven pin");
   chk_half_pins: assert property (~|(port0HalfSupply & (port0PadOe | 8'he0)))
      else $error("half supply misplaced");
   chk_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer stuck");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer late");
   chk_rvalid_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer stuck");
   chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
endmodule // tpg_gpio_properties
bind tpg_gpio tpg_gpio_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_tpg_gpio_properties (
   .sys_clk(sys_clk), .reset(reset),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .port0PadOe(port0PadOe), .port1PadOe(port1PadOe), .port2PadOe(port2PadOe),
   .port0Pullup(port0Pullup), .port0HalfSupply(port0HalfSupply),
   .port2UpperDriveLevel(port2UpperDriveLevel), .port2LowerDriveLevel(port2LowerDriveLevel),
   .port0UpperDriveLevel(port0UpperDriveLevel), .port0LowerDriveLevel(port0LowerDriveLevel)
);

/* tpg_board.sv */
`timescale 1ns/1ps
module tpg_board (
   // Clock
   input wire sys_clk,
   // Device pads
   input wire [23:0] padOut,
   input wire [23:0] padOe,
   input wire [23:0] padPullup,
   output wire [23:0] padIn,
   // External drivers
   input wire [23:0] extDrive,
   input wire [23:0] extLevel
);
   reg [23:0] floatPat_ff = 24'h5a5a5a;
   // Undriven pins toggle so a stale level never passes as valid
   always @(posedge sys_clk) floatPat_ff <= ~floatPat_ff;
   assign padIn = padOe & padOut | ~padOe & (extDrive & extLevel | ~extDrive & (padPullup | floatPat_ff));
endmodule // tpg_board

/* tpg_gpio_tb_top.sv */
`timescale 1ns/1ps
`include "tpg_defines.vh"
module tpg_gpio_tb_top;
   localparam [1:0] OK = `TPG_RESP_OKAY;
   localparam [1:0] ERR = `TPG_RESP_SLVERR;
   // Register indices, entry 0 lowest
   localparam [87:0] IDX = {`TPG_IDX_PORT2_PULL, `TPG_IDX_PORT2_DIR, `TPG_IDX_PORT2_DATA, `TPG_IDX_DISP_COM,
      `TPG_IDX_PORT0_PULL, `TPG_IDX_PORT0_DIR, `TPG_IDX_DRIVE_CFG, `TPG_IDX_PORT1_PULL, `TPG_IDX_PORT1_DIR,
      `TPG_IDX_PORT1_DATA, `TPG_IDX_PORT0_DATA};
   reg sys_clk = 1'b0;
   reg reset = 1'b1;
   reg [11:0] s_axi_awaddr = 12'h000;
   reg [11:0] s_axi_araddr = 12'h000;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'h0;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg [7:0] extDrive = 8'hff;
   integer mismatches = 0;
   integer cmp_count = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] port0PadIn, port1PadIn, port2PadIn, port0PadOut, port1PadOut, port2PadOut, port0HalfSupply;
   wire [7:0] port0PadOe, port1PadOe, port2PadOe, port0Pullup, port1Pullup, port2Pullup;
   wire [1:0] port2UpperDriveLevel, port2LowerDriveLevel, port0UpperDriveLevel, port0LowerDriveLevel;
   wire [7:0] levels = {port2UpperDriveLevel, port2LowerDriveLevel, port0UpperDriveLevel, port0LowerDriveLevel};
   tpg_gpio u_tpg_gpio (.*);
   // External drivers only ever pull low
   tpg_board u_tpg_board (
      .sys_clk(sys_clk),
      .padOut({port2PadOut, port1PadOut, port0PadOut}),
      .padOe({port2PadOe, port1PadOe, port0PadOe}),
      .padPullup({port2Pullup, port1Pullup, port0Pullup}),
      .padIn({port2PadIn, port1PadIn, port0PadIn}),
      .extDrive({3{extDrive}}),
      .extLevel(24'h0)
   );
   always #10 sys_clk = ~sys_clk;
   function [11:0] adr(input integer i);
      adr = {2'h0, IDX[8*i+:8], 2'h0};
   endfunction
   task check(input string what, input [31:0] exp, input [31:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task stop_test;
      begin
         if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task timedOut(input integer n);
      if (n >= 40) begin
         mismatches = mismatches + 1;
         stop_test;
      end
   endtask
   // Pads follow registers one cycle late, reads see a 2-flop sync
   task settle;
      repeat (4) @(posedge sys_clk);
   endtask
   task axiWr(input [11:0] a, input [7:0] d, input [3:0] s, input [1:0] er);
      integer n;
      begin
         n = 0;
         @(posedge sys_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h0, d};
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge sys_clk);
            n = n + 1;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid && n < 40);
         s_axi_bready <= 1'b0;
         timedOut(n);
         check("bresp", er, s_axi_bresp);
      end
   endtask
   task axiRd(input [11:0] a, input [31:0] ed, input [1:0] er);
      integer n;
      begin
         n = 0;
         @(posedge sys_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge sys_clk);
            n = n + 1;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid && n < 40);
         s_axi_rready <= 1'b0;
         timedOut(n);
         check("rresp", er, s_axi_rresp);
         check("rdata", ed, s_axi_rdata);
      end
   endtask
   task testReset;
      integer i;
      begin
         for (i = 0; i < 11; i = i + 1) axiRd(adr(i), 32'h0, OK);
         check("oe", 24'h0, {port0PadOe, port1PadOe, port2PadOe});
         check("pull", 24'h0, {port0Pullup, port1Pullup, port2Pullup});
         check("levels", 8'h0, levels);
         check("pads", 32'h0, {port0PadOut, port1PadOut, port2PadOut, port0HalfSupply});
      end
   endtask
   task testOutput;
      begin
         axiWr(adr(5), 8'hff, 4'h1, OK);
         axiRd(adr(5), 32'h3f, OK);
         axiWr(adr(9), 8'hff, 4'h1, OK);
         axiRd(adr(9), 32'hf3, OK);
         axiWr(adr(0), 8'hea, 4'h1, OK);
         axiWr(adr(8), 8'h5d, 4'h1, OK);
         settle;
         check("oe", 16'h3ff3, {port0PadOe, port2PadOe});
         check("out", 16'h2a51, {port0PadOut, port2PadOut});
         axiRd(adr(0), 32'h2a, OK);
         axiRd(adr(8), 32'h51, OK);
         axiWr(adr(7), 8'hff, 4'h1, OK);
         settle;
         check("half", 16'h1f20, {port0HalfSupply, port0PadOe});
      end
   endtask
   task testPullup;
      begin
         extDrive <= 8'h01;
         axiWr(adr(3), 8'hff, 4'h1, OK);
         settle;
         check("pull1", 8'hcf, port1Pullup);
         axiRd(adr(1), 32'hce, OK);
         axiWr(adr(2), 8'hc0, 4'h1, OK);
         settle;
         check("pull1oe", 16'h0fc0, {port1Pullup, port1PadOe});
         axiRd(adr(1), 32'h0e, OK);
         axiWr(adr(1), 8'hff, 4'h1, OK);
         axiWr(adr(10), 8'hff, 4'h1, OK);
         settle;
         check("out1", 8'hcf, port1PadOut);
         check("pull2", 8'h00, port2Pullup);
         axiRd(adr(1), 32'hce, OK);
         axiRd(adr(10), 32'hf3, OK);
      end
   endtask
   task testLevels;
      integer i;
      reg [7:0] v;
      begin
         for (i = 0; i < 2; i = i + 1) begin
            v = i ? 8'he4 : 8'h1b;
            axiWr(adr(4), v, 4'h1, OK);
            settle;
            check("levels", v, levels);
         end
         axiWr(adr(4), 8'h55, 4'h0, OK);
         axiWr(12'h25e, 8'h55, 4'h1, ERR);
         axiWr(12'h2fc, 8'h55, 4'h1, ERR);
         axiRd(adr(4), 32'he4, OK);
         axiRd(12'h2fc, 32'h0, ERR);
      end
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      testReset;
      testOutput;
      testPullup;
      testLevels;
      stop_test;
   end
endmodule // tpg_gpio_tb_top
